//--- common/mpo_regs.svh
/*
 Register offsets, field positions, reset values and codes of the
 measurement post-processing block.
 Assumes byte offsets on an 8-bit register address, 32-bit data.
*/
`ifndef MPO_REGS_SVH
`define MPO_REGS_SVH
// ********************************
// Offsets
// ********************************
`define MPO_A_WIN   8'h00
`define MPO_A_CALC1 8'h04
`define MPO_A_CALC2 8'h08
`define MPO_A_MVAL  8'h0c
`define MPO_A_MCTL  8'h10
`define MPO_A_MOFS  8'h14
`define MPO_A_OSEL  8'h18
`define MPO_A_DSEL  8'h1c
`define MPO_A_DCNT  8'h20
`define MPO_A_HOLD  8'h24
`define MPO_A_FSEL  8'h28
`define MPO_A_STAT  8'h2c
// ********************************
// Fields and limits
// ********************************
`define MPO_HI_LSB    16
`define MPO_IDX_MAX   9'h1ff
`define MPO_MED_MAX   15'h0009
`define MPO_MOV_MAX   15'h1000
`define MPO_REC_MAX   15'h7fff
`define MPO_DCNT_MAX  22'h2dc6c0
`define MPO_HOLD_MAX  11'h400
`define MPO_NFLD      4'hc
// ********************************
// Reset values and codes
// ********************************
`define MPO_WIN_END_RST 9'h1ff
`define MPO_DCNT_RST    22'h000001
`define MPO_ERR_VAL     32'h80000000
`define MPO_E_WIN       16'h0600
`define MPO_E_RANGE     16'h0236
`endif

//--- common/mpo_pkg.sv
/*
 Types of the measurement post-processing block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package mpo_pkg;
  typedef enum logic [1:0] {MPO_NONE, MPO_MEDIAN, MPO_MOVING, MPO_RECUR} mpo_avg_t;
  typedef enum logic [1:0] {MPO_SRC_CMD, MPO_SRC_MFI, MPO_SRC_KEY} mpo_src_t;
  typedef enum logic [1:0] {MPO_HOLD_OFF, MPO_HOLD_INF, MPO_HOLD_N} mpo_hold_t;
  typedef enum logic {MPO_IDLE, MPO_SEND} mpo_ser_t;
endpackage

//--- design/mpo_core.sv
/*
 Post-processing of the distance stream: two averaging blocks,
 mastering offset, decimation, error hold, output selection and the
 serial field sequencer, with its register file.
 Assumes one sample per measurement cycle, spaced by at least 16 mclk,
 and field inputs held until two mclk after smp_vld, when they are captured.
*/
// Behaviour
// R1: Window start and end lie in 0..511, start below end.
// R2: Two averaging blocks, numbered 1 and 2, on channel one.
// R3: Median over 3, 5, 7 or 9 samples.
// R4: Moving average over a power of two from 2 to 4096.
// R5: Recursive average depth 2 to 32767.
// R6: Delete mode passes the signal through unaveraged.
// R7: Host block label is 2 to 15 alphanumerics, letter first.
// R8: Mastering captures master minus distance, added to later values.
// R9: Mastering reset clears the offset to zero.
// R10: Status shows offset, master value and an active flag.
// R11: Host keeps master value within plus minus twice the range.
// R12: Master value zero makes the current distance read zero.
// R13: Trigger source command, switch input or key; command always works.
// R14: At most one of serial or analog, plus either switch output.
// R15: Decimation enabled per channel, serial and analog separately.
// R16: Count 1 emits all samples, else every n-th up to 3000000.
// R17: Without hold an error value goes out at once.
// R18: Infinite hold repeats the last good value during errors.
// R19: Hold n repeats the good value n cycles, then the error value.
// R20: Serial fields go out in fixed order, readback in same order.
// R21: Twelve selectable serial fields, timestamp split in 16-bit halves.
// R22: Window with start not below end is refused with code 600.
// R23: Averaging, then offset, then hold and decimation, one per cycle.
// R24: Recursive average adds the difference over N each cycle.
`timescale 1ns/1ps
`include "mpo_regs.svh"
module mpo_avg #(
  parameter int W   = 32,
  parameter int MOV = 4096
) (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire logic                 clr,
  input  wire mpo_pkg::mpo_avg_t    mode,
  input  wire logic [14:0]          depth,
  input  wire logic                 in_vld,
  input  wire logic                 in_err,
  input  wire logic signed [W-1:0]  in_d,
  output logic                      out_vld,
  output logic                      out_err,
  output logic signed [W-1:0]       out_d
);
  localparam int AW = $clog2(MOV);
  logic signed [W-1:0]  med_r [8];
  logic signed [W-1:0]  win_c [9];
  logic signed [W-1:0]  mem [MOV];
  logic [3:0]           seen_r;
  logic [AW-1:0]        ptr_r;
  logic [14:0]          fill_r;
  logic signed [W+12:0] sum_r;
  logic signed [W+12:0] sum_nxt;
  logic signed [W-1:0]  rec_r;
  logic signed [W:0]    rec_q;
  logic signed [W-1:0]  med_c;
  logic signed [W-1:0]  old_c;
  logic [3:0]           k_c;
  logic [3:0]           n_c;
  logic [3:0]           rank;
  logic                 take;

  assign take = ce && in_vld && !in_err;

  // ********************************
  // Median by rank counting, ties broken by age
  // ********************************
  always_comb begin
    win_c[0] = in_d;
    for (int i = 1; i < 9; i++) win_c[i] = med_r[i-1];
    n_c = (seen_r + 4'h1 < depth[3:0]) ? seen_r + 4'h1 : depth[3:0];
    med_c = in_d;
    for (int i = 0; i < 9; i++) begin
      rank = 4'h0;
      for (int j = 0; j < 9; j++) begin
        if (j < n_c && (win_c[j] < win_c[i] || (win_c[j] == win_c[i] && j < i))) begin
          rank = rank + 4'h1;
        end
      end
      if (i < n_c && rank == (n_c - 4'h1) >> 1) med_c = win_c[i]; // see R3
    end
  end

  // ********************************
  // Moving sum over a ring and recursive step
  // ********************************
  always_comb begin
    k_c = 4'h1;
    for (int b = 1; b <= AW; b++) begin
      if (depth == 15'(1 << b)) k_c = 4'(b);
    end
    old_c = (fill_r >= depth) ? mem[ptr_r - AW'(depth)] : '0; // see R4
    sum_nxt = sum_r + (W+13)'(in_d) - (W+13)'(old_c);
    rec_q = ((W+1)'(in_d) - (W+1)'(rec_r)) / $signed((W+1)'(depth)); // see R24
  end

  always_ff @(posedge mclk) begin
    if (take) mem[ptr_r] <= in_d;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) med_r[i] <= '0;
      seen_r <= '0;
      ptr_r  <= '0;
      fill_r <= '0;
      sum_r  <= '0;
      rec_r  <= '0;
    end else if (ce && clr) begin
      seen_r <= '0;
      fill_r <= '0;
      sum_r  <= '0;
    end else if (take) begin
      for (int i = 1; i < 8; i++) med_r[i] <= med_r[i-1];
      med_r[0] <= in_d;
      if (seen_r < 4'h8) seen_r <= seen_r + 4'h1;
      ptr_r <= ptr_r + AW'(1);
      if (fill_r < depth) fill_r <= fill_r + 15'h1;
      sum_r <= sum_nxt;
      rec_r <= (seen_r == 4'h0) ? in_d : W'(rec_r + W'(rec_q)); // see R5
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_vld <= 1'b0;
      out_err <= 1'b0;
      out_d   <= '0;
    end else if (ce) begin
      out_vld <= in_vld;
      out_err <= in_err;
      if (in_vld) begin
        case (in_err ? mpo_pkg::MPO_NONE : mode)
          mpo_pkg::MPO_MEDIAN: out_d <= med_c;
          mpo_pkg::MPO_MOVING: out_d <= W'(sum_nxt >>> k_c);
          mpo_pkg::MPO_RECUR:  out_d <= (seen_r == 4'h0) ? in_d : W'(rec_r + W'(rec_q));
          default:             out_d <= in_d; // see R6
        endcase
      end
    end
  end
endmodule

module mpo_core #(
  parameter int MOV = 4096
) (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_we,
  input  wire logic               reg_re,
  output logic [31:0]             reg_rdata,
  input  wire logic               smp_vld,
  input  wire logic               smp_err,
  input  wire logic signed [31:0] smp_dist,
  input  wire logic [31:0]        smp_expo,
  input  wire logic [31:0]        smp_cnt,
  input  wire logic [31:0]        smp_time,
  input  wire logic [31:0]        smp_int,
  input  wire logic [31:0]        smp_state,
  input  wire logic [31:0]        smp_tedge,
  input  wire logic [31:0]        smp_tsmp,
  input  wire logic [31:0]        smp_raw,
  input  wire logic [31:0]        smp_video,
  input  wire logic [31:0]        smp_rate,
  input  wire logic               mfi_pulse,
  input  wire logic               key_pulse,
  output logic [8:0]              win_start,
  output logic [8:0]              win_end,
  output logic                    ana_vld,
  output logic signed [31:0]      ana_data,
  output logic                    switch_output_a,
  output logic                    switch_output_b,
  output logic                    ser_vld,
  output logic [3:0]              ser_id,
  output logic [31:0]             ser_data,
  output logic                    ser_last
);
  logic [1:0]         cmode_r [2];
  logic [14:0]        cdep_r [2];
  logic [1:0]         clr_r;
  logic signed [31:0] mval_r;
  logic signed [31:0] mofs_r;
  logic               mact_r;
  logic               mpend_r;
  logic [1:0]         msrc_r;
  logic [3:0]         osel_r;
  logic [1:0]         dsel_r;
  logic [21:0]        dcnt_r;
  logic [21:0]        dctr_r;
  logic [1:0]         hmode_r;
  logic [10:0]        hn_r;
  logic [10:0]        hctr_r;
  logic signed [31:0] good_r;
  logic [11:0]        fsel_r;
  logic [11:0]        fsel_f;
  logic [15:0]        ecode_r;
  logic [31:0]        fld_r [12];
  logic [3:0]         idx_r;
  mpo_pkg::mpo_ser_t  ser_st;
  logic               a1_vld, a1_err, a2_vld, a2_err;
  logic signed [31:0] a1_d, a2_d;
  logic               wr_win, wr_c0, wr_c1, ok_c0, ok_c1, trig, apply, hit, bad;
  logic signed [31:0] dm_c;
  logic signed [31:0] out_c;

  // ********************************
  // Register writes and checks
  // ********************************
  function automatic logic cfg_ok(input logic [31:0] d);
    logic [14:0] n;
    n = d[`MPO_HI_LSB +: 15];
    case (mpo_pkg::mpo_avg_t'(d[1:0]))
      mpo_pkg::MPO_MEDIAN: cfg_ok = n >= 15'h3 && n <= `MPO_MED_MAX && n[0]; // see R3
      mpo_pkg::MPO_MOVING: cfg_ok = n >= 15'h2 && n <= `MPO_MOV_MAX && (n & (n - 15'h1)) == '0;
      mpo_pkg::MPO_RECUR:  cfg_ok = n >= 15'h2 && n <= `MPO_REC_MAX; // see R5
      default:             cfg_ok = 1'b1; // see R6
    endcase
  endfunction

  assign wr_win = reg_we && reg_addr == `MPO_A_WIN;
  assign bad = reg_wdata[8:0] >= reg_wdata[`MPO_HI_LSB +: 9]; // see R22
  assign wr_c0 = reg_we && reg_addr == `MPO_A_CALC1;
  assign wr_c1 = reg_we && reg_addr == `MPO_A_CALC2;
  assign ok_c0 = cfg_ok(reg_wdata);
  assign ok_c1 = ok_c0;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      win_start <= '0;
      win_end   <= `MPO_WIN_END_RST;
      ecode_r   <= '0;
      for (int i = 0; i < 2; i++) begin
        cmode_r[i] <= '0;
        cdep_r[i]  <= '0;
      end
      clr_r   <= '0;
      mval_r  <= '0;
      msrc_r  <= '0;
      osel_r  <= '0;
      dsel_r  <= '0;
      dcnt_r  <= `MPO_DCNT_RST;
      hmode_r <= '0;
      hn_r    <= '0;
      fsel_r  <= '0;
    end else if (ce) begin
      clr_r <= {wr_c1 && ok_c1, wr_c0 && ok_c0};
      if (wr_win) begin
        if (bad) ecode_r <= `MPO_E_WIN; // see R22
        else begin
          win_start <= reg_wdata[8:0]; // see R1
          win_end   <= reg_wdata[`MPO_HI_LSB +: 9];
          ecode_r   <= '0;
        end
      end
      if (wr_c0 || wr_c1) begin
        if (!ok_c0) ecode_r <= `MPO_E_RANGE;
        else begin
          cmode_r[wr_c1] <= reg_wdata[1:0]; // see R2
          cdep_r[wr_c1]  <= reg_wdata[`MPO_HI_LSB +: 15];
        end
      end
      if (reg_we) begin
        case (reg_addr)
          `MPO_A_MVAL: mval_r <= reg_wdata;
          `MPO_A_MCTL: msrc_r <= reg_wdata[5:4]; // see R13
          `MPO_A_OSEL: begin
            if (reg_wdata[1:0] == 2'b11) ecode_r <= `MPO_E_RANGE;
            else osel_r <= reg_wdata[3:0]; // see R14
          end
          `MPO_A_DSEL: dsel_r <= reg_wdata[1:0]; // see R15
          `MPO_A_DCNT: begin
            if (reg_wdata[21:0] == '0 || reg_wdata[21:0] > `MPO_DCNT_MAX)
              ecode_r <= `MPO_E_RANGE;
            else dcnt_r <= reg_wdata[21:0]; // see R16
          end
          `MPO_A_HOLD: begin
            if (reg_wdata[1:0] == 2'b10 && (reg_wdata[`MPO_HI_LSB +: 11] == '0
                || reg_wdata[`MPO_HI_LSB +: 11] > `MPO_HOLD_MAX))
              ecode_r <= `MPO_E_RANGE;
            else begin
              hmode_r <= reg_wdata[1:0];
              hn_r    <= reg_wdata[`MPO_HI_LSB +: 11];
            end
          end
          `MPO_A_FSEL: fsel_r <= reg_wdata[11:0]; // see R21
          default: ;
        endcase
      end
    end
  end

  // ********************************
  // Register reads
  // ********************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) reg_rdata <= '0;
    else if (ce && reg_re) begin
      case (reg_addr)
        `MPO_A_WIN:   reg_rdata <= {7'h0, win_end, 7'h0, win_start};
        `MPO_A_CALC1: reg_rdata <= {1'b0, cdep_r[0], 14'h0, cmode_r[0]};
        `MPO_A_CALC2: reg_rdata <= {1'b0, cdep_r[1], 14'h0, cmode_r[1]};
        `MPO_A_MVAL:  reg_rdata <= mval_r;
        `MPO_A_MCTL:  reg_rdata <= {26'h0, msrc_r, 4'h0};
        `MPO_A_MOFS:  reg_rdata <= mofs_r; // see R10
        `MPO_A_OSEL:  reg_rdata <= {28'h0, osel_r};
        `MPO_A_DSEL:  reg_rdata <= {30'h0, dsel_r};
        `MPO_A_DCNT:  reg_rdata <= {10'h0, dcnt_r};
        `MPO_A_HOLD:  reg_rdata <= {5'h0, hn_r, 14'h0, hmode_r};
        `MPO_A_FSEL:  reg_rdata <= {20'h0, fsel_r}; // see R20
        `MPO_A_STAT:  reg_rdata <= {14'h0, ser_st == mpo_pkg::MPO_SEND, mact_r, ecode_r};
        default:      reg_rdata <= '0;
      endcase
    end
  end

  // ********************************
  // Averaging chain, block 1 feeds block 2
  // ********************************
  mpo_avg #(.W(32), .MOV(MOV)) u_avg1 (
    .mclk(mclk), .rst(rst), .ce(ce), .clr(clr_r[0]),
    .mode(mpo_pkg::mpo_avg_t'(cmode_r[0])), .depth(cdep_r[0]),
    .in_vld(smp_vld), .in_err(smp_err), .in_d(smp_dist),
    .out_vld(a1_vld), .out_err(a1_err), .out_d(a1_d));
  mpo_avg #(.W(32), .MOV(MOV)) u_avg2 (
    .mclk(mclk), .rst(rst), .ce(ce), .clr(clr_r[1]),
    .mode(mpo_pkg::mpo_avg_t'(cmode_r[1])), .depth(cdep_r[1]),
    .in_vld(a1_vld), .in_err(a1_err), .in_d(a1_d),
    .out_vld(a2_vld), .out_err(a2_err), .out_d(a2_d));

  // ********************************
  // Mastering, applied after averaging
  // ********************************
  assign trig = (ce && reg_we && reg_addr == `MPO_A_MCTL && reg_wdata[0])
    || (msrc_r == 2'(mpo_pkg::MPO_SRC_MFI) && mfi_pulse)
    || (msrc_r == 2'(mpo_pkg::MPO_SRC_KEY) && key_pulse); // see R13
  assign apply = ce && (mpend_r || trig) && a2_vld && !a2_err;
  assign dm_c = apply ? mval_r : 32'(a2_d + mofs_r); // see R8 R12 R23

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mofs_r  <= '0;
      mact_r  <= 1'b0;
      mpend_r <= 1'b0;
    end else if (ce) begin
      mpend_r <= trig || (mpend_r && !apply);
      if (reg_we && reg_addr == `MPO_A_MCTL && reg_wdata[1]) begin
        mofs_r <= '0; // see R9
        mact_r <= 1'b0;
      end else if (apply) begin
        mofs_r <= 32'(mval_r - a2_d); // see R8
        mact_r <= 1'b1;
      end
    end
  end

  // ********************************
  // Error hold and decimation
  // ********************************
  always_comb begin
    out_c = a2_err ? `MPO_ERR_VAL : dm_c; // see R17
    if (a2_err && (hmode_r == 2'(mpo_pkg::MPO_HOLD_INF)
        || (hmode_r == 2'(mpo_pkg::MPO_HOLD_N) && hctr_r < hn_r)))
      out_c = good_r; // see R18 R19
  end
  assign hit = dcnt_r == 22'h1 || dctr_r == dcnt_r - 22'h1; // see R16

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hctr_r <= '0;
      good_r <= `MPO_ERR_VAL;
      dctr_r <= '0;
    end else if (ce && a2_vld) begin
      hctr_r <= a2_err ? ((hctr_r < hn_r) ? hctr_r + 11'h1 : hctr_r) : '0; // see R19
      if (!a2_err) good_r <= dm_c;
      dctr_r <= hit ? '0 : dctr_r + 22'h1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ana_vld         <= 1'b0;
      ana_data        <= '0;
      switch_output_a <= 1'b0;
      switch_output_b <= 1'b0;
    end else if (ce) begin
      ana_vld <= a2_vld && osel_r[1] && (!dsel_r[1] || hit); // see R15
      if (a2_vld) begin
        ana_data        <= out_c;
        switch_output_a <= osel_r[2] && a2_err; // see R14
        switch_output_b <= osel_r[3] && a2_err;
      end
    end
  end

  // ********************************
  // Serial field sequencer, one field per cycle in index order
  // ********************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ser_st   <= mpo_pkg::MPO_IDLE;
      idx_r    <= '0;
      fsel_f   <= '0;
      ser_vld  <= 1'b0;
      ser_id   <= '0;
      ser_data <= '0;
      ser_last <= 1'b0;
      for (int i = 0; i < 12; i++) fld_r[i] <= '0;
    end else if (ce) begin
      ser_vld  <= 1'b0;
      ser_last <= 1'b0;
      case (ser_st)
        mpo_pkg::MPO_IDLE: begin
          if (a2_vld && osel_r[0] && (!dsel_r[0] || hit) && fsel_r != '0) begin
            fld_r[0]  <= out_c;
            fld_r[1]  <= smp_expo;
            fld_r[2]  <= smp_cnt;
            fld_r[3]  <= {16'h0, smp_time[15:0]}; // see R21
            fld_r[4]  <= {16'h0, smp_time[31:16]};
            fld_r[5]  <= smp_int;
            fld_r[6]  <= smp_state;
            fld_r[7]  <= smp_tedge;
            fld_r[8]  <= smp_tsmp;
            fld_r[9]  <= smp_raw;
            fld_r[10] <= smp_video;
            fld_r[11] <= smp_rate;
            fsel_f    <= fsel_r;
            idx_r     <= '0;
            ser_st    <= mpo_pkg::MPO_SEND;
          end
        end
        mpo_pkg::MPO_SEND: begin
          if (fsel_f[idx_r]) begin
            ser_vld  <= 1'b1; // see R20
            ser_id   <= idx_r;
            ser_data <= fld_r[idx_r];
            ser_last <= (fsel_f >> (idx_r + 4'h1)) == '0;
          end
          idx_r <= idx_r + 4'h1;
          if (idx_r == `MPO_NFLD - 4'h1) ser_st <= mpo_pkg::MPO_IDLE;
        end
        default: ser_st <= mpo_pkg::MPO_IDLE;
      endcase
    end
  end

  // ********************************
  // Checks
  // ********************************
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  a_win_order: assert property (win_start < win_end) // see R1
    else $error("window start not below end");
  a_win_reject: assert property (ce && wr_win && bad |=> // see R22
      ecode_r == `MPO_E_WIN && $stable(win_start) && $stable(win_end))
    else $error("bad window applied");
  a_mast_clear: assert property (ce && reg_we && reg_addr == `MPO_A_MCTL && reg_wdata[1]
      |=> mofs_r == '0 && !mact_r) // see R9
    else $error("offset not cleared");
  a_mast_apply: assert property (ce && a2_vld && !a2_err && !apply
      && osel_r[1] |=> ana_data == 32'($past(a2_d) + $past(mofs_r))) // see R8
    else $error("offset not added");
  a_mast_zero: assert property (apply && mval_r == '0 && osel_r[1] && !a2_err
      |=> ana_data == '0) // see R12
    else $error("zero mastering failed");
  a_out_excl: assert property (!(osel_r[0] && osel_r[1])) // see R14
    else $error("serial and analog both on");
  a_hold_off: assert property (ce && a2_vld && a2_err && hmode_r == 2'b00 && osel_r[1]
      && (!dsel_r[1] || hit) |=> ana_vld && ana_data == `MPO_ERR_VAL) // see R17
    else $error("error value not sent");
  a_decim_one: assert property (ce && a2_vld && dcnt_r == 22'h1 && osel_r[1]
      |=> ana_vld) // see R16
    else $error("sample dropped at count one");
  a_ser_order: assert property (ce && ser_vld ##1 ser_vld |-> ser_id > $past(ser_id)) // see R20
    else $error("serial fields out of order");

  c_frame: cover property (ser_vld && ser_last);
  c_hold: cover property (a2_vld && a2_err && hmode_r == 2'b10);
  c_master: cover property (apply);
  c_decim: cover property (a2_vld && dcnt_r > 22'h1 && hit);
endmodule

//--- bench/mpo_host.sv
/*
 Host end of the serial stream: counts fields per frame, flags bad order.
 Assumes single-cycle ser_vld pulses, ser_last on the final field.
*/
`timescale 1ns/1ps
module mpo_host (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ser_vld,
  input  wire logic [3:0]  ser_id,
  input  wire logic [31:0] ser_data,
  input  wire logic        ser_last,
  output logic [4:0]       nfld,
  output logic             order_bad,
  output logic [31:0]      t_lo,
  output logic [31:0]      t_hi
);
  logic [4:0] cnt_r;
  logic [3:0] prev_r;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r <= 5'h00;
      prev_r <= 4'h0;
      nfld <= 5'h00;
      order_bad <= 1'b0;
      t_lo <= 32'h0;
      t_hi <= 32'h0;
    end else if (ser_vld) begin
      // Ids must rise within a frame; sticky so a slip is never lost
      if (cnt_r != 5'h00 && ser_id <= prev_r) begin
        order_bad <= 1'b1;
      end
      prev_r <= ser_id;
      if (ser_id == 4'h3) begin
        t_lo <= ser_data;
      end
      if (ser_id == 4'h4) begin
        t_hi <= ser_data;
      end
      cnt_r <= ser_last ? 5'h00 : cnt_r + 5'h01;
      if (ser_last) begin
        nfld <= cnt_r + 5'h01;
      end
    end
  end
endmodule

//--- bench/testbench.sv
/*
 Self-checking bench of the post-processing core.
 Assumes the host model above and samples spaced by 16 clocks.
*/
`timescale 1ns/1ps
`include "mpo_regs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %0t %h %h", $time, (g), (e)); end end
module testbench;
  logic mclk = 0, rst = 1, ce = 1, we = 0, re = 0, sv = 0, se = 0, multifunction_switch_input = 0, key = 0, got;
  logic [7:0] ad = 0;
  logic [31:0] wd = 0, rdat, r, gd, d, f [11];
  logic [8:0] ws, wen;
  logic av, sa, sb, svl, sl;
  logic signed [31:0] ad_o, sd;
  logic [3:0] sid;
  logic [31:0] sdat, tlo, thi;
  logic [4:0] nf;
  logic obad;
  int num_errors = 0, tests_run = 0, cyc = 0, i, n;
  always #2.5 mclk = ~mclk;
  mpo_core #(.MOV(16)) i_mpo_core (.mclk(mclk), .rst(rst), .ce(ce), .reg_addr(ad),
    .reg_wdata(wd), .reg_we(we), .reg_re(re), .reg_rdata(rdat), .smp_vld(sv), .smp_err(se),
    .smp_dist(sd), .smp_expo(f[0]), .smp_cnt(f[1]), .smp_time(f[2]), .smp_int(f[3]),
    .smp_state(f[4]), .smp_tedge(f[5]), .smp_tsmp(f[6]), .smp_raw(f[7]), .smp_video(f[8]),
    .smp_rate(f[9]), .mfi_pulse(multifunction_switch_input), .key_pulse(key), .win_start(ws), .win_end(wen),
    .ana_vld(av), .ana_data(ad_o), .switch_output_a(sa), .switch_output_b(sb),
    .ser_vld(svl), .ser_id(sid), .ser_data(sdat), .ser_last(sl));
  mpo_host i_mpo_host (.mclk(mclk), .rst(rst), .ser_vld(svl), .ser_id(sid), .ser_data(sdat),
    .ser_last(sl), .nfld(nf), .order_bad(obad), .t_lo(tlo), .t_hi(thi));
  // ****
  // Tasks
  // ****
  task automatic give_verdict();
    if (num_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk) begin we <= 1; ad <= a; wd <= v; end
    @(posedge mclk) we <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk) begin re <= 1; ad <= a; end
    @(posedge mclk) re <= 0;
    @(negedge mclk) v = rdat;
  endtask
  // One sample, then watch the analog port for the rest of its 16-cycle slot
  task automatic smp(input logic [31:0] v, input logic e);
    @(posedge mclk) begin sv <= 1; sd <= v; se <= e; end
    for (int k = 0; k < 10; k++) f[k] <= $urandom;
    @(posedge mclk) sv <= 0;
    got = 0;
    repeat (15) @(negedge mclk) if (av === 1'b1) begin got = 1; gd = ad_o; end
  endtask
  function automatic logic [31:0] med3(input logic [31:0] a, b, c);
    return (a > b) ? ((b > c) ? b : (a > c ? c : a)) : ((a > c) ? a : (b > c ? c : b));
  endfunction
  always @(posedge mclk) if (++cyc == 20000) begin num_errors++; give_verdict(); end
  // ****
  // Scenarios
  // ****
  initial begin
    for (i = 0; i < 11; i++) f[i] = 0;
    sd = 0;
    void'($urandom(6422));
    repeat (8) @(posedge mclk);
    rst <= 0;
    rd(`MPO_A_WIN, r); `CHK(r[24:16], `MPO_WIN_END_RST)
    wr(`MPO_A_WIN, 32'h01230045); @(negedge mclk); `CHK({wen, ws}, {9'h123, 9'h045})
    // Clock enable low: the write must leave no trace
    @(posedge mclk) ce <= 0;
    wr(`MPO_A_WIN, 32'h00100001);
    @(posedge mclk) ce <= 1;
    @(negedge mclk); `CHK({wen, ws}, {9'h123, 9'h045})
    wr(`MPO_A_WIN, 32'h00050005); rd(`MPO_A_STAT, r); `CHK(r[15:0], `MPO_E_WIN)
    `CHK({wen, ws}, {9'h123, 9'h045})
    wr(`MPO_A_OSEL, 32'h2);
    d = $urandom % 5000; smp(d, 0); `CHK(gd, d)
    wr(`MPO_A_CALC1, 32'h00030001); // Block picked by number, host label stays out
    smp(10, 0); smp(30, 0); smp(20, 0); `CHK(gd, med3(10, 30, 20))
    wr(`MPO_A_CALC1, 32'h0); wr(`MPO_A_CALC2, 32'h00020002);
    smp(10, 0); smp(30, 0); `CHK(gd, (32'd10 + 32'd30) >> 1)
    wr(`MPO_A_CALC2, 32'h0); wr(`MPO_A_CALC1, 32'h00040003);
    smp(100, 0); smp(20, 0); `CHK(gd, 32'(100 + (20 - 100) / 4))
    wr(`MPO_A_CALC1, 32'h0); smp(d, 0); `CHK(gd, d)
    wr(`MPO_A_MVAL, 32'h0); wr(`MPO_A_MCTL, 32'h1); // Master value kept in range
    smp(d, 0); `CHK(gd, 32'h0)
    rd(`MPO_A_STAT, r); `CHK(r[16], 1'b1)
    smp(d + 5, 0); `CHK(gd, 32'h5)
    wr(`MPO_A_MCTL, 32'h2); rd(`MPO_A_STAT, r); `CHK(r[16], 1'b0)
    smp(d, 0); `CHK(gd, d)
    wr(`MPO_A_MVAL, 32'h64); wr(`MPO_A_MCTL, 32'h10);
    @(posedge mclk) multifunction_switch_input <= 1;
    @(posedge mclk) multifunction_switch_input <= 0;
    smp(d, 0); `CHK(gd, 32'h64)
    wr(`MPO_A_MCTL, 32'h20);
    @(posedge mclk) key <= 1;
    @(posedge mclk) key <= 0;
    smp(d + 3, 0); `CHK(gd, 32'h64)
    wr(`MPO_A_MCTL, 32'h2);
    smp(7, 0); smp(1, 1); `CHK(gd, `MPO_ERR_VAL)
    wr(`MPO_A_HOLD, 32'h00020002); smp(9, 0);
    for (i = 0; i < 3; i++) begin smp(1, 1); `CHK(gd, (i < 2) ? 32'h9 : `MPO_ERR_VAL) end
    wr(`MPO_A_HOLD, 32'h1); smp(4, 0);
    for (i = 0; i < 4; i++) begin smp(1, 1); `CHK(gd, 32'h4) end
    wr(`MPO_A_HOLD, 32'h0);
    wr(`MPO_A_DSEL, 32'h2); wr(`MPO_A_DCNT, 32'h3); n = 0;
    for (i = 0; i < 6; i++) begin smp($urandom % 900, 0); n += got; end
    `CHK(n, 2)
    wr(`MPO_A_DCNT, 32'h0); rd(`MPO_A_STAT, r); `CHK(r[15:0], `MPO_E_RANGE)
    wr(`MPO_A_DSEL, 32'h0);
    wr(`MPO_A_WIN, 32'h01230045); rd(`MPO_A_STAT, r); `CHK(r[15:0], 16'h0)
    wr(`MPO_A_OSEL, 32'h3); rd(`MPO_A_STAT, r); `CHK(r[15:0], `MPO_E_RANGE)
    rd(`MPO_A_OSEL, r); `CHK(r[1:0], 2'h2)
    wr(`MPO_A_OSEL, 32'h1); wr(`MPO_A_FSEL, 32'hfff);
    smp(d, 0); `CHK(got, 1'b0)
    repeat (2) @(negedge mclk);
    `CHK(nf, 5'hc)
    `CHK(obad, 1'b0)
    `CHK({tlo, thi}, {16'h0, f[2][15:0], 16'h0, f[2][31:16]})
    wr(`MPO_A_FSEL, 32'h018); smp(d, 0); `CHK(nf, 5'h2)
    give_verdict();
  end
endmodule
